// ==== logic/osr_regs.svh ====
`ifndef OSR_REGS_SVH
`define OSR_REGS_SVH

// ****************************************************
// register offsets
// ****************************************************
`define OSR_A_FLAGS      8'h00
`define OSR_A_MASK       8'h01
`define OSR_A_WR_IDX     8'h02
`define OSR_A_LOST       8'h03
`define OSR_A_RD_IDX     8'h04
`define OSR_A_PORT       8'h05
`define OSR_A_OPCTL      8'h06
`define OSR_A_OXY        8'h07
`define OSR_A_SPARE08    8'h08
`define OSR_A_EMIT       8'h09
`define OSR_A_SPARE_LO   8'h0a
`define OSR_A_SPARE_HI   8'h15
`define OSR_A_TWHOLE     8'h16
`define OSR_A_TPART      8'h17
`define OSR_A_SPARE8D    8'h8d
`define OSR_A_REV        8'hfe
`define OSR_A_DEVID      8'hff

// ****************************************************
// field positions and codes
// ****************************************************
`define OSR_F_NEARLY_FULL 7
`define OSR_F_TEMP_DONE   6
`define OSR_F_PULSE_DONE  5
`define OSR_F_OXY_DONE    4
`define OSR_F_SUPPLY_GOOD 0
`define OSR_MASK_BITS     8'hf0
`define OSR_OPCTL_PDOWN   7
`define OSR_OPCTL_TEMP_EN 3
`define OSR_MODE_PULSE    3'h2
`define OSR_MODE_OXY      3'h3
`define OSR_RST_VALUE     8'h00
`define OSR_SLAVE_ADDR    7'h57
`define OSR_LOST_MAX      4'hf

// ****************************************************
// timing
// ****************************************************
`define OSR_CLK_HZ   50000000
`define OSR_CLK_MHZ  50
`define OSR_PW_MIN_US 200
`define OSR_SR_HZ_0  50
`define OSR_SR_HZ_1  100
`define OSR_SR_HZ_2  167
`define OSR_SR_HZ_3  200
`define OSR_SR_HZ_4  400
`define OSR_SR_HZ_5  600
`define OSR_SR_HZ_6  800
`define OSR_SR_HZ_7  1000

`endif

// ==== logic/osr_pkg.sv ====
package osr_pkg;

    typedef enum logic [1:0] {KIND_PTR, KIND_WR, KIND_RD} osr_kind_t;

    typedef enum logic [2:0] {
        L_IDLE, L_ADDR, L_WRB, L_ACK, L_RDB, L_MACK
    } osr_lstate_t;

    typedef struct packed {
        logic [15:0][31:0] store;
        logic [3:0] wr;
        logic [3:0] rd;
        logic [3:0] lost;
        logic full;
        logic [1:0] byte_idx;
        logic [7:0] flags;
        logic [7:0] mask;
        logic [7:0] ptr;
        logic [7:0] rdata;
        logic pdown;
        logic temp_en;
        logic [2:0] mode;
        logic hi_res;
        logic [2:0] rate;
        logic [1:0] pw;
        logic [3:0] red_emitter_current;
        logic [3:0] infrared_emitter_current;
        logic [7:0] temp_whole;
        logic [3:0] temp_frac;
        logic [7:0] spare08;
        logic [7:0] spare8d;
        logic [11:0][7:0] spare_blk;
        logic [7:0] dev_code;
        logic [19:0] tmr;
        logic conv_start;
        logic temp_start;
        logic emit_on;
        logic int_oe;
        logic int_lo;
        logic sup1;
        logic sup2;
        logic sup3;
        logic rq1;
        logic rq2;
        logic rq3;
        logic ack_tgl;
    } osr_core_t;

    typedef struct packed {
        logic scl1;
        logic scl2;
        logic scl3;
        logic sda1;
        logic sda2;
        logic sda3;
        logic ak1;
        logic ak2;
        logic ak3;
        osr_lstate_t st;
        logic [3:0] bitcnt;
        logic [7:0] sh;
        logic first;
        logic rd;
        logic sda_oe;
        logic sda_lo;
        logic rq_tgl;
        osr_kind_t rq_kind;
        logic [7:0] rq_data;
        logic [7:0] rdata;
    } osr_link_t;

endpackage

// ==== logic/osr_top.sv ====
`timescale 1ns/100ps
`include "osr_regs.svh"
module osr_top
    import osr_pkg::*;
#(
    // arbitrary values, not tied to any product
    parameter logic [7:0] REVISION_CODE = 8'h3c,
    parameter logic [7:0] DEVICE_CODE = 8'h5a,
    parameter logic [19:0] PW_BASE_CYC = 20'(`OSR_PW_MIN_US * `OSR_CLK_MHZ),
    parameter logic [19:0] RATE_CYC [8] = '{
        20'(`OSR_CLK_HZ / `OSR_SR_HZ_0), 20'(`OSR_CLK_HZ / `OSR_SR_HZ_1),
        20'(`OSR_CLK_HZ / `OSR_SR_HZ_2), 20'(`OSR_CLK_HZ / `OSR_SR_HZ_3),
        20'(`OSR_CLK_HZ / `OSR_SR_HZ_4), 20'(`OSR_CLK_HZ / `OSR_SR_HZ_5),
        20'(`OSR_CLK_HZ / `OSR_SR_HZ_6), 20'(`OSR_CLK_HZ / `OSR_SR_HZ_7)}
) (
    // clocks and reset
    input wire logic clk_i,
    input wire logic lnk_clk_i,
    input wire logic sys_rst_i,
    // serial register port
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // interrupt pin
    output logic int_o,
    output logic int_oe_o,
    // converter side
    input wire logic sample_valid_i,
    input wire logic [15:0] ir_data_i,
    input wire logic [15:0] red_data_i,
    input wire logic temp_valid_i,
    input wire logic [7:0] temp_whole_i,
    input wire logic [3:0] temp_frac_i,
    input wire logic supply_good_i,
    // front-end controls
    output logic conv_start_o,
    output logic emitter_on_o,
    output logic temp_start_o,
    output logic power_down_o,
    output logic high_res_o,
    output logic [3:0] red_current_o,
    output logic [3:0] ir_current_o
);

    osr_core_t c_r;
    osr_core_t c_nxt;
    osr_link_t l_r;
    osr_link_t l_nxt;
    logic lrst1_r;
    logic lrst2_r;

    // ****************************************************
    // register read mux
    // ****************************************************
    function automatic logic [7:0] rd_byte(input osr_core_t c);
        logic [31:0] ent;
        ent = c.store[c.rd];
        rd_byte = 8'h00;
        if (c.ptr >= `OSR_A_SPARE_LO && c.ptr <= `OSR_A_SPARE_HI) begin
            rd_byte = c.spare_blk[4'(c.ptr - `OSR_A_SPARE_LO)];
        end
        unique case (c.ptr)
            `OSR_A_FLAGS: rd_byte = c.flags & 8'hf1;
            `OSR_A_MASK: rd_byte = c.mask;
            `OSR_A_WR_IDX: rd_byte = {4'h0, c.wr};
            `OSR_A_LOST: rd_byte = {4'h0, c.lost};
            `OSR_A_RD_IDX: rd_byte = {4'h0, c.rd};
            `OSR_A_PORT: begin
                unique case (c.byte_idx)
                    2'd0: rd_byte = ent[31:24];
                    2'd1: rd_byte = ent[23:16];
                    2'd2: rd_byte = ent[15:8];
                    2'd3: rd_byte = ent[7:0];
                endcase
            end
            `OSR_A_OPCTL: rd_byte = {c.pdown, 3'h0, c.temp_en, c.mode};
            `OSR_A_OXY: rd_byte = {1'b0, c.hi_res, 1'b0, c.rate, c.pw};
            `OSR_A_SPARE08: rd_byte = c.spare08;
            `OSR_A_EMIT: rd_byte = {c.red_emitter_current, c.infrared_emitter_current};
            `OSR_A_TWHOLE: rd_byte = c.temp_whole;
            `OSR_A_TPART: rd_byte = {4'h0, c.temp_frac};
            `OSR_A_SPARE8D: rd_byte = c.spare8d;
            `OSR_A_REV: rd_byte = REVISION_CODE;
            `OSR_A_DEVID: rd_byte = c.dev_code;
            default: ;
        endcase
    endfunction

    // ****************************************************
    // core domain
    // ****************************************************
    always_comb begin
        logic running;
        logic oxy;
        logic [7:0] set;
        logic [7:0] clr;
        logic [3:0] wr1;
        logic [7:0] wa;
        logic [7:0] wd;
        running = 1'b0;
        oxy = 1'b0;
        set = 8'h00;
        clr = 8'h00;
        wr1 = 4'h0;
        wa = 8'h00;
        wd = 8'h00;
        c_nxt = c_r;
        c_nxt.conv_start = 1'b0;
        c_nxt.temp_start = 1'b0;
        c_nxt.sup1 = supply_good_i;
        c_nxt.sup2 = c_r.sup1;
        c_nxt.sup3 = c_r.sup2;
        c_nxt.rq1 = l_r.rq_tgl;
        c_nxt.rq2 = c_r.rq1;
        c_nxt.rq3 = c_r.rq2;
        oxy = c_r.mode == `OSR_MODE_OXY;
        running = !c_r.pdown && (oxy || c_r.mode == `OSR_MODE_PULSE);

        // sample pacing and emitter pulse
        if (running) begin
            if (c_r.tmr >= RATE_CYC[c_r.rate] - 20'd1) begin
                c_nxt.tmr = 20'd0;
                c_nxt.conv_start = 1'b1;
            end else begin
                c_nxt.tmr = c_r.tmr + 20'd1;
            end
            // wide pulses at fast rates simply hold the emitter on
            c_nxt.emit_on = c_nxt.tmr < (PW_BASE_CYC << c_r.pw);
        end else begin
            // parked at the wrap point so the first pulse is full length
            c_nxt.tmr = RATE_CYC[c_r.rate] - 20'd1;
            c_nxt.emit_on = 1'b0;
        end

        // push a converted sample
        if (running && sample_valid_i) begin
            set[`OSR_F_PULSE_DONE] = 1'b1;
            set[`OSR_F_OXY_DONE] = oxy;
            if (c_r.full) begin
                if (c_r.lost != `OSR_LOST_MAX) begin
                    c_nxt.lost = c_r.lost + 4'd1;
                end
            end else begin
                c_nxt.store[c_r.wr] = {ir_data_i,
                    oxy ? red_data_i : 16'h0000};
                wr1 = c_r.wr + 4'd1;
                c_nxt.wr = wr1;
                c_nxt.full = wr1 == c_r.rd;
                if (wr1 == c_r.rd - 4'd1) begin
                    set[`OSR_F_NEARLY_FULL] = 1'b1;
                end
            end
        end

        // temperature conversion
        if (c_r.temp_en && temp_valid_i) begin
            c_nxt.temp_whole = temp_whole_i;
            c_nxt.temp_frac = temp_frac_i;
            c_nxt.temp_en = 1'b0;
            set[`OSR_F_TEMP_DONE] = 1'b1;
        end

        // supply comes up
        if (c_r.sup2 && !c_r.sup3) begin
            set[`OSR_F_SUPPLY_GOOD] = 1'b1;
        end

        // host access arriving from the link domain
        if (c_r.rq2 != c_r.rq3) begin
            c_nxt.ack_tgl = ~c_r.ack_tgl;
            wa = c_r.ptr;
            wd = l_r.rq_data;
            unique case (l_r.rq_kind)
                KIND_PTR: c_nxt.ptr = wd;
                KIND_WR: begin
                    if (wa != `OSR_A_DEVID && wa != `OSR_A_PORT) begin
                        c_nxt.ptr = wa + 8'd1;
                    end
                    if (wa >= `OSR_A_SPARE_LO && wa <= `OSR_A_SPARE_HI) begin
                        c_nxt.spare_blk[4'(wa - `OSR_A_SPARE_LO)] = wd;
                    end
                    unique case (wa)
                        `OSR_A_MASK: c_nxt.mask = wd & `OSR_MASK_BITS;
                        `OSR_A_WR_IDX: begin
                            c_nxt.wr = wd[3:0];
                            c_nxt.full = 1'b0;
                        end
                        `OSR_A_LOST: c_nxt.lost = wd[3:0];
                        `OSR_A_RD_IDX: begin
                            c_nxt.rd = wd[3:0];
                            c_nxt.full = 1'b0;
                            c_nxt.byte_idx = 2'd0;
                        end
                        `OSR_A_OPCTL: begin
                            c_nxt.pdown = wd[`OSR_OPCTL_PDOWN];
                            c_nxt.mode = wd[2:0];
                            c_nxt.temp_en = wd[`OSR_OPCTL_TEMP_EN];
                            c_nxt.temp_start = wd[`OSR_OPCTL_TEMP_EN];
                        end
                        `OSR_A_OXY: begin
                            c_nxt.hi_res = wd[6];
                            c_nxt.rate = wd[4:2];
                            c_nxt.pw = wd[1:0];
                        end
                        `OSR_A_SPARE08: c_nxt.spare08 = wd;
                        `OSR_A_EMIT: begin
                            c_nxt.red_emitter_current = wd[7:4];
                            c_nxt.infrared_emitter_current = wd[3:0];
                        end
                        `OSR_A_TWHOLE: c_nxt.temp_whole = wd;
                        `OSR_A_TPART: c_nxt.temp_frac = wd[3:0];
                        `OSR_A_SPARE8D: c_nxt.spare8d = wd;
                        `OSR_A_DEVID: c_nxt.dev_code = wd;
                        default: ;
                    endcase
                end
                KIND_RD: begin
                    c_nxt.rdata = rd_byte(c_r);
                    if (wa != `OSR_A_DEVID && wa != `OSR_A_PORT) begin
                        c_nxt.ptr = wa + 8'd1;
                    end
                    if (wa == `OSR_A_FLAGS || wa == `OSR_A_PORT) begin
                        clr = 8'hff;
                    end
                    if (wa == `OSR_A_TWHOLE) begin
                        clr[`OSR_F_TEMP_DONE] = 1'b1;
                    end
                    if (wa == `OSR_A_PORT) begin
                        c_nxt.byte_idx = c_r.byte_idx + 2'd1;
                        if (c_r.byte_idx == 2'd3) begin
                            c_nxt.rd = c_r.rd + 4'd1;
                            c_nxt.full = 1'b0;
                            c_nxt.lost = 4'h0;
                        end
                    end
                end
                default: ;
            endcase
        end

        // an event in the clearing cycle survives
        c_nxt.flags = ((c_r.flags & ~clr) | set) & 8'hf1;
        c_nxt.int_oe = |(c_nxt.flags & c_nxt.mask)
            | c_nxt.flags[`OSR_F_SUPPLY_GOOD];
        c_nxt.int_lo = 1'b0;
        if (sys_rst_i) begin
            c_nxt = '0;
            c_nxt.dev_code = DEVICE_CODE;
        end
    end

    always_ff @(posedge clk_i) begin
        c_r <= c_nxt;
    end

    // ****************************************************
    // link domain reset
    // ****************************************************
    always_ff @(posedge lnk_clk_i) begin
        lrst1_r <= sys_rst_i;
        lrst2_r <= lrst1_r;
    end

    // ****************************************************
    // link domain: serial slave engine
    // ****************************************************
    always_comb begin
        logic rise;
        logic fall;
        logic start;
        logic stop;
        rise = 1'b0;
        fall = 1'b0;
        start = 1'b0;
        stop = 1'b0;
        l_nxt = l_r;
        l_nxt.scl1 = scl_i;
        l_nxt.scl2 = l_r.scl1;
        l_nxt.scl3 = l_r.scl2;
        l_nxt.sda1 = sda_i;
        l_nxt.sda2 = l_r.sda1;
        l_nxt.sda3 = l_r.sda2;
        l_nxt.ak1 = c_r.ack_tgl;
        l_nxt.ak2 = l_r.ak1;
        l_nxt.ak3 = l_r.ak2;
        rise = l_r.scl2 && !l_r.scl3;
        fall = !l_r.scl2 && l_r.scl3;
        start = l_r.scl2 && l_r.scl3 && !l_r.sda2 && l_r.sda3;
        stop = l_r.scl2 && l_r.scl3 && l_r.sda2 && !l_r.sda3;
        if (l_r.ak2 != l_r.ak3) begin
            l_nxt.rdata = c_r.rdata;
        end
        if (start) begin
            l_nxt.st = L_ADDR;
            l_nxt.bitcnt = 4'd0;
            l_nxt.first = 1'b1;
            l_nxt.sda_oe = 1'b0;
        end else if (stop) begin
            l_nxt.st = L_IDLE;
            l_nxt.sda_oe = 1'b0;
        end else begin
            unique case (l_r.st)
                L_IDLE: ;
                L_ADDR, L_WRB: begin
                    if (rise) begin
                        l_nxt.sh = {l_r.sh[6:0], l_r.sda2};
                        l_nxt.bitcnt = l_r.bitcnt + 4'd1;
                    end else if (fall && l_r.bitcnt == 4'd8) begin
                        l_nxt.st = L_ACK;
                        l_nxt.sda_oe = 1'b1;
                        l_nxt.rq_tgl = ~l_r.rq_tgl;
                        l_nxt.rq_data = l_r.sh;
                        if (l_r.st == L_ADDR) begin
                            l_nxt.rd = l_r.sh[0];
                            l_nxt.rq_kind = KIND_RD;
                            if (l_r.sh[7:1] != `OSR_SLAVE_ADDR) begin
                                l_nxt.st = L_IDLE;
                                l_nxt.sda_oe = 1'b0;
                                l_nxt.rq_tgl = l_r.rq_tgl;
                            end else if (!l_r.sh[0]) begin
                                l_nxt.rq_tgl = l_r.rq_tgl;
                            end
                        end else begin
                            l_nxt.rq_kind = l_r.first ? KIND_PTR : KIND_WR;
                            l_nxt.first = 1'b0;
                        end
                    end
                end
                L_ACK: begin
                    if (fall) begin
                        l_nxt.bitcnt = 4'd0;
                        l_nxt.st = l_r.rd ? L_RDB : L_WRB;
                        l_nxt.sh = l_r.rdata;
                        l_nxt.sda_oe = l_r.rd && !l_r.rdata[7];
                    end
                end
                L_RDB: begin
                    if (fall) begin
                        l_nxt.bitcnt = l_r.bitcnt + 4'd1;
                        l_nxt.sh = {l_r.sh[6:0], 1'b0};
                        l_nxt.sda_oe = !l_r.sh[6];
                        if (l_r.bitcnt == 4'd7) begin
                            l_nxt.st = L_MACK;
                            l_nxt.sda_oe = 1'b0;
                        end
                    end
                end
                L_MACK: begin
                    if (rise) begin
                        if (!l_r.sda2) begin
                            l_nxt.st = L_ACK;
                            l_nxt.rq_tgl = ~l_r.rq_tgl;
                            l_nxt.rq_kind = KIND_RD;
                        end else begin
                            l_nxt.st = L_IDLE;
                        end
                    end
                end
            endcase
        end
        l_nxt.sda_lo = 1'b0;
        if (lrst2_r) begin
            l_nxt = '0;
        end
    end

    always_ff @(posedge lnk_clk_i) begin
        l_r <= l_nxt;
    end

    // ****************************************************
    // outputs
    // ****************************************************
    assign sda_o = l_r.sda_lo;
    assign sda_oe_o = l_r.sda_oe;
    assign int_o = c_r.int_lo;
    assign int_oe_o = c_r.int_oe;
    assign conv_start_o = c_r.conv_start;
    assign emitter_on_o = c_r.emit_on;
    assign temp_start_o = c_r.temp_start;
    assign power_down_o = c_r.pdown;
    assign high_res_o = c_r.hi_res;
    assign red_current_o = c_r.red_emitter_current;
    assign ir_current_o = c_r.infrared_emitter_current;

endmodule

// ==== verif/osr_chk_sva.sv ====
`timescale 1ns/100ps
module osr_chk #(
    parameter logic [19:0] PW_BASE_CYC = 20'd20,
    parameter int SR_GAP = 200
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // pins
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic int_o,
    input wire logic int_oe_o,
    input wire logic supply_good_i,
    // front end
    input wire logic conv_start_o,
    input wire logic emitter_on_o,
    input wire logic temp_start_o,
    input wire logic power_down_o
);
    // ****************
    // helper counters
    // ****************
    logic [15:0] hi_r, gap_r;
    logic [7:0] idle_r;
    logic seen_r;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            hi_r <= 16'h0;
            gap_r <= 16'h0;
            idle_r <= 8'h0;
            seen_r <= 1'b0;
        end else begin
            hi_r <= emitter_on_o ? hi_r + 16'h1 : 16'h0;
            gap_r <= conv_start_o ? 16'h0 : gap_r + 16'h1;
            seen_r <= seen_r | conv_start_o;
            // saturate, a long idle bus must not wrap under the bound
            if (!(scl_i && sda_i))
                idle_r <= 8'h0;
            else if (idle_r != 8'hff)
                idle_r <= idle_r + 8'h1;
        end
    end
    // ****************
    // properties
    // ****************
    AST_INT_OPEN_DRAIN: assert property (!int_o)
        else $error("interrupt pin driven high");
    AST_IRQ_HELD: assert property (
        int_oe_o && idle_r > 8'd40 |=> int_oe_o)
        else $error("interrupt released while bus idle");
    AST_SUPPLY_IRQ: assert property (
        $rose(supply_good_i) |-> ##[2:8] int_oe_o)
        else $error("supply rise did not pull interrupt");
    AST_RESET_QUIET: assert property (disable iff (1'b0)
        sys_rst_i |=> !(int_oe_o || temp_start_o || conv_start_o ||
        emitter_on_o || power_down_o))
        else $error("output active after reset");
    AST_TEMP_PULSE: assert property (temp_start_o |=> !temp_start_o)
        else $error("temperature start longer than one cycle");
    AST_PULSE_WIDTH: assert property (
        $fell(emitter_on_o) |-> hi_r == 16'(PW_BASE_CYC) ||
        hi_r == 16'(PW_BASE_CYC << 1) || hi_r == 16'(PW_BASE_CYC << 2) ||
        hi_r == 16'(PW_BASE_CYC << 3))
        else $error("emitter pulse width off");
    AST_EMIT_WITH_CONV: assert property (
        conv_start_o |-> ##[0:2] emitter_on_o)
        else $error("no emitter pulse at conversion start");
    AST_RATE_GAP: assert property (
        conv_start_o && seen_r |-> gap_r >= 16'(SR_GAP - 1))
        else $error("conversions closer than sample period");
    COV_IRQ: cover property ($rose(int_oe_o));
    COV_TEMP: cover property (temp_start_o);
    COV_EMIT: cover property ($fell(emitter_on_o));
endmodule

// ==== verif/osr_host.sv ====
`timescale 1ns/100ps
module osr_host #(
    parameter int T_LOW = 1300,
    parameter int T_HIGH = 600
) (
    // bus wires
    output logic scl_o,
    output logic sda_lo_o,
    input wire logic sda_i
);
    logic [31:0] nak_n;
    initial begin
        scl_o = 1'b1;
        sda_lo_o = 1'b0;
        nak_n = 32'h0;
    end
    // ****************
    // bit level
    // ****************
    // data changes only mid-low, so it never looks like start or stop
    task automatic bitx(input logic b, output logic r);
        #(T_LOW / 2);
        sda_lo_o = !b;
        #(T_LOW / 2);
        scl_o = 1'b1;
        #(T_HIGH / 2);
        r = sda_i;
        #(T_HIGH / 2);
        scl_o = 1'b0;
    endtask
    task automatic start();
        #(T_LOW / 2);
        sda_lo_o = 1'b0;
        #(T_LOW / 2);
        scl_o = 1'b1;
        #T_HIGH;
        sda_lo_o = 1'b1;
        #T_HIGH;
        scl_o = 1'b0;
    endtask
    task automatic stop();
        #(T_LOW / 2);
        sda_lo_o = 1'b1;
        #(T_LOW / 2);
        scl_o = 1'b1;
        #T_HIGH;
        sda_lo_o = 1'b0;
        #T_LOW;
    endtask
    task automatic xfer(input logic [7:0] d, input logic ak,
                        output logic [7:0] q, output logic n);
        for (int i = 7; i >= 0; i--)
            bitx(d[i], q[i]);
        bitx(ak, n);
    endtask
    task automatic put(input logic [7:0] d);
        logic [7:0] q;
        logic n;
        xfer(d, 1'b1, q, n);
        if (n !== 1'b0)
            nak_n++;
    endtask
    // ****************
    // transactions
    // ****************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        start();
        put(8'hae);
        put(a);
        put(d);
        stop();
    endtask
    task automatic rd(input logic [7:0] a, input int n,
                      output logic [31:0] q);
        logic [7:0] b;
        logic x;
        q = 32'h0;
        start();
        put(8'hae);
        put(a);
        start();
        put(8'haf);
        for (int i = 0; i < n; i++) begin
            xfer(8'hff, i == n - 1, b, x);
            q = {q[23:0], b};
        end
        stop();
    endtask
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
    // ****************
    // signals
    // ****************
    typedef struct packed {
        logic [7:0] a, rv, w, e;
    } osr_row_t;
    osr_row_t rows [4] = '{
        '{8'h01, 8'h00, 8'hff, 8'hf0}, '{8'h15, 8'h00, 8'h5a, 8'h5a},
        '{8'h8d, 8'h00, 8'hc3, 8'hc3}, '{8'hfe, 8'h3c, 8'h00, 8'h3c}};
    logic clk_i, lnk_clk_i, sys_rst_i, sample_valid_i, temp_valid_i;
    logic [15:0] ir_data_i, red_data_i;
    logic [7:0] temp_whole_i;
    logic [3:0] temp_frac_i;
    logic supply_good_i, scl_w, host_lo, sda_w, sda_o, sda_oe_o;
    logic int_o, int_oe_o, conv_start_o, emitter_on_o, temp_start_o;
    logic pd_w, hr_w;
    logic [3:0] red_w, ir_w;
    logic [31:0] err_count, n_checks, starts;
    assign sda_w = !(host_lo || (sda_oe_o && !sda_o));
    always #10 clk_i = ~clk_i;
    initial begin
        lnk_clk_i = 1'b0;
        #7;
        forever #24 lnk_clk_i = ~lnk_clk_i;
    end
    always @(posedge clk_i)
        if (temp_start_o === 1'b1)
            starts++;
    osr_host u_host (.scl_o(scl_w), .sda_lo_o(host_lo), .sda_i(sda_w));
    osr_top #(
        .PW_BASE_CYC(20'd20),
        .RATE_CYC('{20'd200, 20'd180, 20'd160, 20'd140,
            20'd120, 20'd100, 20'd80, 20'd60})
    ) uut (
        .clk_i(clk_i), .lnk_clk_i(lnk_clk_i), .sys_rst_i(sys_rst_i),
        .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .int_o(int_o), .int_oe_o(int_oe_o),
        .sample_valid_i(sample_valid_i), .ir_data_i(ir_data_i),
        .red_data_i(red_data_i), .temp_valid_i(temp_valid_i),
        .temp_whole_i(temp_whole_i), .temp_frac_i(temp_frac_i),
        .supply_good_i(supply_good_i), .conv_start_o(conv_start_o),
        .emitter_on_o(emitter_on_o), .temp_start_o(temp_start_o),
        .power_down_o(pd_w), .high_res_o(hr_w), .red_current_o(red_w),
        .ir_current_o(ir_w));
    // ****************
    // tasks
    // ****************
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        chk_reg({31'h0, got}, {31'h0, exp});
    endtask
    task automatic push(input logic [7:0] i);
        @(posedge clk_i);
        sample_valid_i <= 1'b1;
        ir_data_i <= {8'h11, i};
        red_data_i <= {8'h22, i};
        @(posedge clk_i);
        sample_valid_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // serial traffic needs about 1.95 ms, so 2.1 ms means a hang
    initial begin
        #2_100_000;
        err_count++;
        conclude();
    end
    initial begin
        logic [31:0] q;
        {clk_i, sample_valid_i, temp_valid_i, supply_good_i} = 4'h0;
        {ir_data_i, red_data_i, temp_whole_i, temp_frac_i} = 44'h0;
        {err_count, n_checks, starts} = 96'h0;
        sys_rst_i = 1'b1;
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        foreach (rows[k]) begin
            u_host.rd(rows[k].a, 1, q);
            chk_reg(q, {24'h0, rows[k].rv});
            u_host.wr(rows[k].a, rows[k].w);
            u_host.rd(rows[k].a, 1, q);
            chk_reg(q, {24'h0, rows[k].e});
        end
        u_host.wr(8'h07, 8'h40);
        u_host.wr(8'h09, 8'ha5);
        chk_reg({22'h0, pd_w, hr_w, red_w, ir_w}, 32'h1a5);
        $display("test registers done");
        @(posedge clk_i);
        supply_good_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk_pin(int_oe_o, 1'b1);
        u_host.rd(8'h00, 1, q);
        chk_reg(q, 32'h01);
        chk_pin(int_oe_o, 1'b0);
        $display("test supply done");
        u_host.wr(8'h06, 8'h03);
        for (int i = 0; i < 15; i++)
            push(i[7:0]);
        chk_pin(int_oe_o, 1'b1);
        u_host.rd(8'h00, 1, q);
        chk_reg(q, 32'hb0);
        push(8'h0f);
        push(8'h10);
        u_host.rd(8'h02, 3, q);
        chk_reg(q, 32'h000100);
        u_host.rd(8'h05, 4, q);
        chk_reg(q, 32'h11002200);
        chk_pin(int_oe_o, 1'b0);
        u_host.rd(8'h00, 1, q);
        chk_reg(q, 32'h00);
        u_host.rd(8'h03, 2, q);
        chk_reg(q, 32'h0001);
        $display("test store done");
        u_host.wr(8'h01, 8'h00);
        u_host.wr(8'h06, 8'h0a);
        @(posedge clk_i);
        temp_valid_i <= 1'b1;
        temp_whole_i <= 8'h19;
        temp_frac_i <= 4'h7;
        @(posedge clk_i);
        temp_valid_i <= 1'b0;
        push(8'h20);
        repeat (5) @(posedge clk_i);
        chk_pin(int_oe_o, 1'b0);
        u_host.rd(8'h00, 1, q);
        chk_reg(q, 32'h60);
        u_host.rd(8'h16, 2, q);
        chk_reg(q, 32'h1907);
        u_host.rd(8'h06, 1, q);
        chk_reg(q, 32'h02);
        chk_reg(starts, 32'h1);
        chk_reg(u_host.nak_n, 32'h0);
        $display("test temperature done");
        conclude();
    end
endmodule
bind osr_top osr_chk #(.PW_BASE_CYC(PW_BASE_CYC), .SR_GAP(RATE_CYC[0])) u_chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_i(sda_i),
    .int_o(int_o), .int_oe_o(int_oe_o), .supply_good_i(supply_good_i),
    .conv_start_o(conv_start_o), .emitter_on_o(emitter_on_o),
    .temp_start_o(temp_start_o), .power_down_o(power_down_o));
